// *** wdt_top.sv ***
// watchdog with once-writable mode register and restart key register
`timescale 1ns/100ps
module wdt_top (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic opt_fixed_slow_i,
  input wire logic slow_tick_i,
  input wire logic peri_tick_i,
  input wire logic peri_clk_run_i,
  input wire logic osc_settling_i,
  input wire logic halt_i,
  input wire logic stop_i,
  input wire logic [15:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic bit_op_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic chip_reset_o,
  output logic wdt_reset_flag_o,
  output logic [wdt_pkg::WDT_CNT_W-1:0] count_o
);
  import wdt_pkg::*;

  logic rst_s1_q;
  logic rst_n;
  logic opt_fixed_q;
  logic opt_taken_q;
  logic [4:0] mode_q;
  wdt_state_t state_q;
  wdt_state_t state_d;
  logic mode_wr;
  logic key_wr;
  logic key_bad;
  logic second_wr;
  logic stopped;
  logic tick;
  logic clear;
  logic ovf;
  logic fault;
  logic [4:0] exp_sel;
  logic [7:0] rdata_d;
  logic [4:0] mode_new;
  logic chip_reset_q;
  logic flag_q;

  // peripheral clock chosen by the clock select pair
  function automatic logic wdt_is_peri(input logic [4:0] mode);
    return mode[WDT_CSEL_HI:WDT_CSEL_LO] == WDT_CSEL_PERI;
  endfunction : wdt_is_peri

  // overflow exponent for the chosen clock and interval code
  function automatic logic [4:0] wdt_exp(input logic [4:0] mode);
    if (wdt_is_peri(mode)) begin
      return 5'(WDT_PERI_BASE) + {2'b00, mode[2:0]};
    end
    return 5'(WDT_SLOW_BASE) + {2'b00, mode[2:0]};
  endfunction : wdt_exp

  // reset released through two flops
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // option strap caught once after release
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      opt_fixed_q <= 1'b1;
      opt_taken_q <= 1'b0;
    end else if (!opt_taken_q) begin
      opt_fixed_q <= opt_fixed_slow_i;
      opt_taken_q <= 1'b1;
    end
  end

  assign mode_wr = ce_i && wr_i && (addr_i == WDT_MODE_ADDR);
  assign key_wr = ce_i && wr_i && (addr_i == WDT_KEY_ADDR);
  assign key_bad = key_wr && (bit_op_i || wdata_i != WDT_KEY_RESTART);
  assign stopped = (state_q == WDT_ST_STOPPED);
  assign second_wr = mode_wr && (state_q != WDT_ST_ARMED);

  // bit ops on the mode register are not honoured as the one write, but count as a second write once it is taken
  always_comb begin
    mode_new = wdata_i[4:0];
    if (opt_fixed_q) begin
      mode_new[WDT_CSEL_HI] = 1'b0;
      mode_new[WDT_CSEL_LO] = 1'b0;
    end
  end

  // a stop chosen in the one accepted write is final until reset
  always_comb begin
    state_d = state_q;
    case (state_q)
      WDT_ST_ARMED: begin
        if (mode_wr && !bit_op_i) begin
          if (mode_new[WDT_CSEL_HI]) state_d = WDT_ST_STOPPED;
          else state_d = WDT_ST_LOCKED;
        end
      end
      WDT_ST_LOCKED: state_d = WDT_ST_LOCKED;
      WDT_ST_STOPPED: state_d = WDT_ST_STOPPED;
      default: state_d = WDT_ST_LOCKED;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= WDT_ST_ARMED;
    end else if (ce_i) begin
      state_q <= state_d;
    end
  end

  // mode register; top bits are hardwired so written top bits are dropped
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= WDT_MODE_RESET[4:0];
    end else if (ce_i && state_q == WDT_ST_ARMED && mode_wr && !bit_op_i) begin
      mode_q <= mode_new;
    end
  end

  // slow clock runs on in fixed option, even in STOP
  always_comb begin
    if (opt_fixed_q) begin
      tick = slow_tick_i;
    end else if (halt_i || stop_i || stopped) begin
      tick = 1'b0;
    end else if (wdt_is_peri(mode_q)) begin
      tick = peri_tick_i && peri_clk_run_i && !osc_settling_i;
    end else begin
      tick = slow_tick_i;
    end
  end

  assign exp_sel = wdt_exp(mode_q);

  assign clear = (key_wr && !key_bad) || (mode_wr && !bit_op_i && state_q == WDT_ST_ARMED);

  // a restart in the overflow cycle wins, so a late service is still honoured
  wdt_counter #(
    .CNT_W(WDT_CNT_W)
  ) u_cnt (
    .clk_i(clk_i),
    .rst_ni(rst_n),
    .ce_i(ce_i),
    .clear_i(clear),
    .tick_i(tick),
    .exp_i(exp_sel),
    .ovf_o(ovf),
    .count_o(count_o)
  );

  // faults suppressed while stopped
  assign fault = ce_i && !stopped && (second_wr || key_bad || ovf);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      chip_reset_q <= 1'b0;
    end else if (ce_i) begin
      chip_reset_q <= fault;
    end
  end
  assign chip_reset_o = chip_reset_q;

  // flag survives the chip reset it causes; only rstn_i clears it
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_q <= 1'b0;
    end else if (ce_i && fault) begin
      flag_q <= 1'b1;
    end
  end
  assign wdt_reset_flag_o = flag_q;

  always_comb begin
    if (addr_i == WDT_MODE_ADDR) begin
      rdata_d = {WDT_MODE_TOP, mode_q};
    end else if (addr_i == WDT_KEY_ADDR) begin
      rdata_d = WDT_KEY_RESET;
    end else begin
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= 8'h00;
    end else if (ce_i && rd_i) begin
      rdata_o <= rdata_d;
    end
  end

  // reset requests and what may raise them
  AST_RESET_AFTER_FAULT: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    fault |=> chip_reset_o)
    else $error("fault did not reset chip");

  AST_NO_RESET_STOPPED: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (ce_i && stopped) |=> !chip_reset_o)
    else $error("reset while stopped");

  AST_SECOND_WRITE: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (ce_i && mode_wr && state_q == WDT_ST_LOCKED) |=> chip_reset_o)
    else $error("second mode write not punished");

  AST_BAD_KEY: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (key_wr && !stopped && wdata_i != WDT_KEY_RESTART) |=> chip_reset_o)
    else $error("bad key ignored");

  AST_BIT_KEY: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (key_wr && !stopped && bit_op_i) |=> chip_reset_o)
    else $error("bit key ignored");

  AST_GOOD_KEY_CLEARS: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (key_wr && !bit_op_i && wdata_i == WDT_KEY_RESTART) |=> count_o == '0)
    else $error("restart did not clear");

  AST_FIXED_SLOW: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (opt_taken_q && opt_fixed_q) |-> mode_q[WDT_CSEL_HI:WDT_CSEL_LO] == WDT_CSEL_SLOW)
    else $error("clock select changed in fixed option");

  AST_KEY_READ: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (ce_i && rd_i && addr_i == WDT_KEY_ADDR) |=> rdata_o == WDT_KEY_RESET)
    else $error("key read wrong");

  AST_HOLD_IN_HALT: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (ce_i && !opt_fixed_q && halt_i && !clear) |=> $stable(count_o))
    else $error("count moved in halt");

  AST_FLAG_SET: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    chip_reset_o |-> wdt_reset_flag_o)
    else $error("flag missing");

  AST_FLAG_STICKY: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    wdt_reset_flag_o |=> wdt_reset_flag_o)
    else $error("flag dropped without reset");

  AST_RESET_HAS_CAUSE: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    $rose(chip_reset_o) |-> $past(fault))
    else $error("reset without a cause");

  // mode register lifetime
  AST_MODE_AFTER_RESET: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    !opt_taken_q |-> (mode_q == WDT_MODE_RESET[4:0] && state_q == WDT_ST_ARMED))
    else $error("mode not at reset value");

  AST_MODE_WRITE_CLEARS: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (mode_wr && !bit_op_i && state_q == WDT_ST_ARMED) |=> count_o == '0)
    else $error("mode write did not clear");

  AST_STATE_ONCE: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (ce_i && state_q != WDT_ST_ARMED) |=> $stable(state_q))
    else $error("mode register reopened");

  AST_MODE_FROZEN: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (ce_i && state_q != WDT_ST_ARMED) |=> $stable(mode_q))
    else $error("mode changed after the one write");

  AST_MODE_READ: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (ce_i && rd_i && addr_i == WDT_MODE_ADDR) |=> rdata_o[7:5] == WDT_MODE_TOP)
    else $error("mode top bits read wrong");

  // counting and gating
  AST_FIXED_RUNS_IN_STOP: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (ce_i && opt_fixed_q && stop_i && slow_tick_i && !clear && !ovf)
    |=> count_o == $past(count_o) + 1'b1)
    else $error("fixed option stopped counting");

  AST_SLOW_COUNTS: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (ce_i && !stopped && !wdt_is_peri(mode_q) && (opt_fixed_q || (!halt_i && !stop_i))
     && slow_tick_i && !clear && !ovf) |=> count_o == $past(count_o) + 1'b1)
    else $error("slow tick not counted");

  AST_PERI_GATED: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (ce_i && !opt_fixed_q && wdt_is_peri(mode_q) && !(peri_clk_run_i && !osc_settling_i)
     && !clear) |=> $stable(count_o))
    else $error("count moved with peripheral clock gated");

  AST_HOLD_IN_STOP: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (ce_i && !opt_fixed_q && stop_i && !clear) |=> $stable(count_o))
    else $error("count moved in stop");

  AST_STOPPED_HOLDS: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (ce_i && stopped && !clear) |=> $stable(count_o))
    else $error("count moved while stopped");

  AST_OVF_RESTARTS: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (ce_i && ovf) |=> count_o == '0)
    else $error("count not restarted after overflow");

  AST_CE_FREEZE: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    !ce_i |=> ($stable(count_o) && $stable(state_q) && $stable(mode_q)
     && $stable(rdata_o) && $stable(chip_reset_o)))
    else $error("state moved with clock enable low");
endmodule : wdt_top

// *** wdt_pkg.sv ***
// shared constants for the once-write watchdog
package wdt_pkg;
  localparam logic [15:0] WDT_MODE_ADDR = 16'hff48;
  localparam logic [15:0] WDT_KEY_ADDR = 16'hff49;
  localparam logic [7:0] WDT_MODE_RESET = 8'h67;
  localparam logic [7:0] WDT_KEY_RESET = 8'h9a;
  localparam logic [7:0] WDT_KEY_RESTART = 8'hac;
  localparam logic [2:0] WDT_MODE_TOP = 3'h3;
  localparam int WDT_CSEL_HI = 4;
  localparam int WDT_CSEL_LO = 3;
  localparam int WDT_SLOW_BASE = 11;
  localparam int WDT_PERI_BASE = 13;
  localparam int WDT_CNT_W = 21;
  localparam logic [1:0] WDT_CSEL_SLOW = 2'h0;
  localparam logic [1:0] WDT_CSEL_PERI = 2'h1;
  localparam int WDT_RESET_CAUSE_REGISTER_BIT = 4;
  typedef enum logic [2:0] {
    WDT_ST_ARMED = 3'b001,
    WDT_ST_LOCKED = 3'b010,
    WDT_ST_STOPPED = 3'b100
  } wdt_state_t;
endpackage : wdt_pkg

// *** wdt_counter.sv ***
// gated overflow counter with power-of-two period select
`timescale 1ns/100ps
module wdt_counter #(
  parameter int CNT_W = wdt_pkg::WDT_CNT_W
) (
  input wire logic clk_i,
  input wire logic rst_ni,
  input wire logic ce_i,
  input wire logic clear_i,
  input wire logic tick_i,
  input wire logic [4:0] exp_i,
  output logic ovf_o,
  output logic [CNT_W-1:0] count_o
);
  import wdt_pkg::*;
  logic [CNT_W-1:0] limit;

  // longest period is 2^20 peripheral clocks, so anything narrower cannot serve it
  if (CNT_W < WDT_CNT_W) begin : g_cnt_w_check
    $error("counter narrower than longest period");
  end

  assign limit = CNT_W'(({{(CNT_W-1){1'b0}}, 1'b1} << exp_i) - 1'b1);
  assign ovf_o = tick_i && !clear_i && (count_o == limit);

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      count_o <= '0;
    end else if (ce_i) begin
      if (clear_i || ovf_o) begin
        count_o <= '0;
      end else if (tick_i) begin
        count_o <= count_o + 1'b1;
      end
    end
  end
endmodule : wdt_counter

// *** wdt_cpu_model.sv ***
// cpu side model issuing byte accesses to the watchdog registers
`timescale 1ns/100ps
module wdt_cpu_model (
  input wire logic clk_i,
  output logic [15:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic bit_op_o,
  output logic [7:0] wdata_o
);
  initial begin
    addr_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
    bit_op_o = 1'b0;
    wdata_o = 8'h00;
  end
  // one access per call, held for exactly one rising edge
  task automatic access(input logic [15:0] a, input logic [7:0] d, input logic w,
                        input logic b);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = w;
    rd_o = !w;
    bit_op_o = b;
    @(negedge clk_i);
    wr_o = 1'b0;
    rd_o = 1'b0;
    bit_op_o = 1'b0;
    // a released bus does not keep the last value
    addr_o = ~a;
    wdata_o = ~d;
  endtask : access
endmodule : wdt_cpu_model

// *** wdt_top_tb.sv ***
// self-checking bench for the once-write watchdog
`timescale 1ns/100ps
module wdt_top_tb;
  import wdt_pkg::*;
  typedef struct {logic opt; logic [7:0] mode; logic slow; logic peri; int per;} wdt_row_t;
  logic clk_i, rstn_i, opt_i, slow_on, peri_on, halt_i, stop_i, wr, rd, bop, chip_rst, flag;
  logic ce, peri_run, settling;
  logic [15:0] addr;
  logic [7:0] wdata, rdata;
  logic [WDT_CNT_W-1:0] cnt, c;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  // fixed option rows write junk on purpose: clock select and top bits must be ignored
  wdt_row_t rows [5] = '{'{1'b0, 8'h60, 1'b1, 1'b0, 2048}, '{1'b0, 8'h61, 1'b1, 1'b0, 4096},
    '{1'b0, 8'h68, 1'b0, 1'b1, 8192}, '{1'b1, 8'h1a, 1'b1, 1'b0, 8192},
    '{1'b1, 8'h09, 1'b1, 1'b0, 4096}};
  wdt_cpu_model i_wdt_cpu_model (.clk_i(clk_i), .addr_o(addr), .wr_o(wr), .rd_o(rd),
    .bit_op_o(bop), .wdata_o(wdata));
  wdt_top i_wdt_top (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce), .opt_fixed_slow_i(opt_i),
    .slow_tick_i(slow_on), .peri_tick_i(peri_on), .peri_clk_run_i(peri_run),
    .osc_settling_i(settling), .halt_i(halt_i), .stop_i(stop_i), .addr_i(addr), .wr_i(wr),
    .rd_i(rd), .bit_op_i(bop), .wdata_i(wdata), .rdata_o(rdata), .chip_reset_o(chip_rst),
    .wdt_reset_flag_o(flag), .count_o(cnt));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 100000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // tick sources are given here so no caller drives them again in the same step
  task automatic reset(input logic opt, input logic slow, input logic peri);
    rstn_i = 1'b0;
    opt_i = opt;
    ce = 1'b1;
    peri_run = 1'b1;
    settling = 1'b0;
    slow_on = 1'b0;
    peri_on = 1'b0;
    halt_i = 1'b0;
    stop_i = 1'b0;
    repeat (10) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (3) @(negedge clk_i);
    slow_on = slow;
    peri_on = peri;
  endtask : reset
  // an access whose reset request is checked in the cycle it stands
  task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic b,
                     input logic exp);
    i_wdt_cpu_model.access(a, d, 1'b1, b);
    chk(chip_rst, exp);
  endtask : acc
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    i_wdt_cpu_model.access(a, 8'h00, 1'b0, 1'b0);
    chk(rdata, exp);
  endtask : rd_chk
  task automatic complete_run;
    if (fail_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  initial begin
    reset(1'b0, 1'b1, 1'b0);
    foreach (rows[i]) begin
      reset(rows[i].opt, rows[i].slow, rows[i].peri);
      acc(WDT_MODE_ADDR, rows[i].mode, 1'b0, 1'b0);
      chk(cnt, '0);
      repeat (rows[i].per - 1) @(negedge clk_i);
      chk(chip_rst, 1'b0);
      @(negedge clk_i);
      chk(chip_rst, 1'b1);
      rd_chk(WDT_MODE_ADDR, {3'b011, rows[i].opt ? 2'b00 : rows[i].mode[4:3],
        rows[i].mode[2:0]});
    end
    reset(1'b0, 1'b1, 1'b0);
    rd_chk(WDT_MODE_ADDR, 8'h67);
    rd_chk(WDT_KEY_ADDR, 8'h9a);
    rd_chk(16'hff4a, 8'h00);
    c = cnt;
    @(negedge clk_i);
    chk(cnt, c + 1'b1);
    acc(WDT_KEY_ADDR, WDT_KEY_RESTART, 1'b0, 1'b0);
    chk(cnt, '0);
    rd_chk(WDT_KEY_ADDR, 8'h9a);
    acc(WDT_MODE_ADDR, 8'h60, 1'b1, 1'b0);
    rd_chk(WDT_MODE_ADDR, 8'h67);
    acc(WDT_MODE_ADDR, 8'h60, 1'b0, 1'b0);
    acc(WDT_MODE_ADDR, 8'h60, 1'b0, 1'b1);
    chk(flag, 1'b1);
    reset(1'b0, 1'b1, 1'b0);
    acc(WDT_KEY_ADDR, 8'h00, 1'b0, 1'b1);
    reset(1'b0, 1'b1, 1'b0);
    acc(WDT_KEY_ADDR, WDT_KEY_RESTART, 1'b1, 1'b1);
    reset(1'b0, 1'b1, 1'b0);
    acc(WDT_MODE_ADDR, 8'h98, 1'b0, 1'b0);
    repeat (50) @(negedge clk_i);
    chk(cnt, '0);
    acc(WDT_KEY_ADDR, 8'h00, 1'b0, 1'b0);
    acc(WDT_KEY_ADDR, WDT_KEY_RESTART, 1'b1, 1'b0);
    acc(WDT_MODE_ADDR, 8'h60, 1'b0, 1'b0);
    reset(1'b0, 1'b1, 1'b0);
    halt_i = 1'b1;
    @(negedge clk_i);
    c = cnt;
    repeat (20) @(negedge clk_i);
    chk(cnt, c);
    halt_i = 1'b0;
    @(negedge clk_i);
    chk(cnt, c + 1'b1);
    stop_i = 1'b1;
    @(negedge clk_i);
    c = cnt;
    repeat (20) @(negedge clk_i);
    chk(cnt, c);
    stop_i = 1'b0;
    @(negedge clk_i);
    chk(cnt, c + 1'b1);
    // peripheral clock gating, then a frozen clock enable
    reset(1'b0, 1'b0, 1'b1);
    acc(WDT_MODE_ADDR, 8'h6f, 1'b0, 1'b0);
    peri_run = 1'b0;
    @(negedge clk_i);
    c = cnt;
    repeat (10) @(negedge clk_i);
    chk(cnt, c);
    peri_run = 1'b1;
    settling = 1'b1;
    repeat (10) @(negedge clk_i);
    chk(cnt, c);
    settling = 1'b0;
    @(negedge clk_i);
    chk(cnt, c + 1'b1);
    ce = 1'b0;
    @(negedge clk_i);
    c = cnt;
    acc(WDT_KEY_ADDR, 8'h00, 1'b0, 1'b0);
    repeat (10) @(negedge clk_i);
    chk(cnt, c);
    ce = 1'b1;
    @(negedge clk_i);
    chk(cnt, c + 1'b1);
    reset(1'b1, 1'b1, 1'b0);
    stop_i = 1'b1;
    @(negedge clk_i);
    c = cnt;
    repeat (10) @(negedge clk_i);
    chk(cnt, c + 21'd10);
    complete_run();
  end
endmodule : wdt_top_tb
